// ===== hfh_host.sv
// Host controller driving the half-flash converter through its read pins.
// Assumes device pins synchronous to i_clk; wait line pull-up is external.
// Function
// - Pipelined reads spaced at least 2.5 us
// - Stall mode only with stretched reads
// - Wait line pull-up is external to the host
// - Low address bits select channel
// - Done low may end stretched read
`timescale 1ns/100ps
module hfh_host
  import hfh_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = 2 * hfh_pkg::GAP_CYCLES
) (
  input wire logic i_clk, // System clock, 250 MHz
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic i_ce, // Clock enable
  input wire hfh_pkg::hfh_mode_t i_mode, // Stall or pipelined
  input wire logic i_bipolar, // Result is offset binary
  input wire logic i_req, // Read request pulse
  input wire logic [hfh_pkg::CHAN_W-1:0] i_chan, // Channel for this read
  output logic o_busy, // Request not accepted now
  output logic o_valid, // Result pulse
  output logic [hfh_pkg::DATA_W-1:0] o_data, // Result; top bit flipped when i_bipolar
  output logic [hfh_pkg::CHAN_W-1:0] o_data_chan, // Channel of o_data
  output logic o_timeout, // Stall read never ended
  output logic o_cs_n, // Chip select to device
  output logic o_rd_n, // Read strobe to device
  output logic [hfh_pkg::CHAN_W-1:0] o_chan_sel, // Channel address pins
  input wire logic [hfh_pkg::DATA_W-1:0] i_result_bus, // Device byte bus
  input wire logic i_wait, // Wait line level with pull-up
  input wire logic i_done_n // Conversion done, active low
);
  typedef enum logic [1:0] {ST_IDLE, ST_STALL, ST_PIPE, ST_GAP} hfh_state_t;
  hfh_state_t state, next_state;
  logic cs_n, next_cs_n;
  logic [CHAN_W-1:0] chan, next_chan;
  logic [CHAN_W-1:0] prev_chan, next_prev_chan;
  logic [DATA_W-1:0] data, next_data;
  logic [CHAN_W-1:0] data_chan, next_data_chan;
  logic valid, next_valid;
  logic tout, next_tout;
  logic first, next_first;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_value;
  logic cnt_zero;

  hfh_counter #(.W(CNT_W)) u_cnt (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_load(cnt_load),
    .i_value(cnt_value),
    .o_zero(cnt_zero)
  );

  function automatic logic [DATA_W-1:0] fmt(input logic [DATA_W-1:0] d, input logic bip);
    fmt = bip ? (d ^ BIP_MASK) ^ 8'hff : d;
  endfunction

  always_comb begin
    next_state = state;
    next_cs_n = cs_n;
    next_chan = chan;
    next_prev_chan = prev_chan;
    next_data = data;
    next_data_chan = data_chan;
    next_valid = 1'b0;
    next_tout = 1'b0;
    next_first = first;
    cnt_load = 1'b0;
    cnt_value = '0;
    unique case (state)
      ST_IDLE: begin
        if (i_req) begin
          next_cs_n = 1'b0;
          next_chan = i_chan;
          cnt_load = 1'b1;
          cnt_value = (i_mode == HFH_STALL) ? CNT_W'(TIMEOUT_CYCLES)
                                            : CNT_W'(STROBE_CYCLES);
          next_state = (i_mode == HFH_STALL) ? ST_STALL : ST_PIPE;
        end
      end
      ST_STALL: begin
        if (i_wait && !i_done_n && cnt_load == 1'b0 && !first) begin
          next_data = fmt(i_result_bus, i_bipolar);
          next_data_chan = chan;
          next_valid = 1'b1;
          next_cs_n = 1'b1;
          next_state = ST_GAP;
          cnt_load = 1'b1;
          cnt_value = CNT_W'(1);
        end else if (cnt_zero && !first) begin
          next_tout = 1'b1;
          next_cs_n = 1'b1;
          next_state = ST_GAP;
          cnt_load = 1'b1;
          cnt_value = CNT_W'(1);
        end
        next_first = 1'b0;
      end
      ST_PIPE: begin
        if (cnt_zero && !first) begin
          next_data = fmt(i_result_bus, i_bipolar);
          next_data_chan = prev_chan;
          next_prev_chan = chan;
          next_valid = 1'b1;
          next_cs_n = 1'b1;
          next_state = ST_GAP;
          cnt_load = 1'b1;
          cnt_value = CNT_W'(GAP_CYCLES);
        end
        next_first = 1'b0;
      end
      ST_GAP: begin
        if (cnt_zero) begin
          next_state = ST_IDLE;
        end
      end
    endcase
    if (next_state != state && next_state != ST_IDLE && next_state != ST_GAP) begin
      next_first = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      cs_n <= 1'b1;
      chan <= CHAN_RST;
      prev_chan <= CHAN_RST;
      data <= DATA_RST;
      data_chan <= CHAN_RST;
      valid <= 1'b0;
      tout <= 1'b0;
      first <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      cs_n <= next_cs_n;
      chan <= next_chan;
      prev_chan <= next_prev_chan;
      data <= next_data;
      data_chan <= next_data_chan;
      valid <= next_valid;
      tout <= next_tout;
      first <= next_first;
    end
  end

  logic busy;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy <= 1'b0;
    end else if (i_ce) begin
      busy <= (next_state != ST_IDLE);
    end
  end

  assign o_cs_n = cs_n;
  assign o_rd_n = cs_n;
  assign o_chan_sel = chan;
  assign o_data = data;
  assign o_data_chan = data_chan;
  assign o_valid = valid;
  assign o_timeout = tout;
  assign o_busy = busy;

  // wait pull-up is board level; host reads released line as high
  AST_STROBES_HIGH_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == ST_IDLE) |-> o_cs_n)
    else $error("Strobes low while idle");
  AST_CHAN_STABLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!o_cs_n && !$past(o_cs_n) && i_ce) |-> $stable(o_chan_sel))
    else $error("Channel changed during read");
  AST_PIPE_STROBE_LEN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ($fell(o_cs_n) && state == ST_PIPE && i_ce) |-> !o_cs_n [*4])
    else $error("Pipelined read too short");
  AST_GAP_HIGH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == ST_GAP) |-> o_cs_n)
    else $error("Strobes low in gap");
  AST_VALID_ENDS_READ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_valid && i_ce) |-> o_cs_n)
    else $error("Result while strobes low");
  AST_STALL_DONE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == ST_STALL && !first && i_wait && !i_done_n && i_ce) |=> o_valid)
    else $error("Stall read not ended on ready");
  AST_BUSY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state != ST_IDLE && i_ce) |-> o_busy)
    else $error("Busy low during read");
  AST_TIMEOUT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_timeout |-> !o_valid)
    else $error("Timeout with result");
  COV_STALL: cover property (@(posedge i_clk) state == ST_STALL ##[1:1000] o_valid);
  COV_PIPE: cover property (@(posedge i_clk) state == ST_PIPE ##[1:20] o_valid);
  COV_TOUT: cover property (@(posedge i_clk) o_timeout);
endmodule // hfh_host

// ===== hfh_pkg.sv
// Package for the half-flash converter host read port.
// Assumes a 250 MHz system clock; conversion and read gap cycle counts derived here.
package hfh_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  // Conversion time in ns, and gap between reads in ns
  localparam int unsigned CONV_TIME_NS = 2000;
  localparam int unsigned READ_GAP_NS = 2500;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned GAP_CYCLES = (READ_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Least strobe-low time in a pipelined read, in cycles
  localparam int unsigned STROBE_CYCLES = 4;
  localparam int unsigned CNT_W = 12;
  localparam int unsigned CHAN_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  // Bipolar mode result is offset binary: mask then invert flips only the top bit
  localparam logic [DATA_W-1:0] BIP_MASK = 8'h7f;
  typedef enum logic [0:0] {HFH_STALL, HFH_PIPE} hfh_mode_t;
endpackage

// ===== hfh_counter.sv
// Down counter used for read spacing and timeouts.
// Assumes a synchronous active-low reset and a common clock enable.
`timescale 1ns/100ps
module hfh_counter #(
  parameter int unsigned W = 12
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic i_load, // Load start value
  input wire logic [W-1:0] i_value, // Start value
  output logic o_zero // Count has run out
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (i_load) begin
      next_cnt = i_value;
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt <= '0;
    end else if (i_ce) begin
      cnt <= next_cnt;
    end
  end
  assign o_zero = (cnt == '0);
endmodule // hfh_counter

// ===== hfh_dev_model.sv
// Behavioural converter seen from its read pins.
// Assumes strobes synchronous to i_clk; the wait pull-up is modelled here.
`timescale 1ns/100ps
module hfh_dev_model (
  input wire logic i_clk, // System clock
  input wire hfh_pkg::hfh_mode_t i_mode, // Static mode strap
  input wire logic i_hang, // Conversion never ends
  input wire logic i_cs_n, // Chip select
  input wire logic i_rd_n, // Read strobe
  input wire logic [hfh_pkg::CHAN_W-1:0] i_chan_sel, // Channel pins
  output logic [hfh_pkg::DATA_W-1:0] o_result_bus, // Bus as seen
  output logic o_wait, // Wait level, pulled up
  output logic o_done_n // Conversion done
);
  import hfh_pkg::*;
  logic strobe;
  logic strobe_q = 1'b0, conv = 1'b0, done_q = 1'b1;
  logic [CNT_W-1:0] cnt = '0;
  logic [CHAN_W-1:0] chan = '0;
  logic [DATA_W-1:0] res = 8'h00, last = 8'h00;
  assign strobe = !i_cs_n && !i_rd_n;
  assign o_done_n = done_q;
  always @(posedge i_clk) begin
    strobe_q <= strobe;
    last <= o_result_bus;
    if (strobe && !strobe_q) begin
      chan <= i_chan_sel;
      conv <= 1'b1;
      cnt <= CNT_W'(CONV_CYCLES - 1);
    end else if (conv && !i_hang) begin
      cnt <= cnt - 1'b1;
      if (cnt == '0) begin
        conv <= 1'b0;
        res <= {chan, 5'h0b};
        done_q <= 1'b0;
      end
    end
    if (!strobe && strobe_q) done_q <= 1'b1;
  end
  always_comb begin
    o_wait = 1'b1;
    // Floating bus toggles so a stale byte never looks valid
    o_result_bus = ~last;
    if (strobe && (i_mode == HFH_PIPE || conv || !strobe_q)) o_wait = 1'b0;
    if (strobe && (i_mode == HFH_PIPE || (!conv && strobe_q))) o_result_bus = res;
  end
endmodule // hfh_dev_model

// ===== hfh_tb.sv
// Self-checking bench for the host read port.
// Assumes the converter model on the far side of the pins.
`timescale 1ns/100ps
module tb;
  import hfh_pkg::*;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_req = 1'b0, i_bipolar = 1'b0, hang = 1'b0;
  logic to_seen = 1'b0, got;
  logic ce = 1'b1;
  hfh_mode_t i_mode = HFH_STALL;
  logic [CHAN_W-1:0] i_chan = '0, o_data_chan, o_chan_sel;
  logic o_busy, o_valid, o_timeout, o_cs_n, o_rd_n, wait_lvl, done_n;
  logic [DATA_W-1:0] o_data, bus;
  int num_errors = 0;
  int cmp_count = 0;
  always #2 i_clk = ~i_clk;
  hfh_host i_hfh_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_mode(i_mode),
    .i_bipolar(i_bipolar), .i_req(i_req), .i_chan(i_chan), .o_busy(o_busy),
    .o_valid(o_valid), .o_data(o_data), .o_data_chan(o_data_chan), .o_timeout(o_timeout),
    .o_cs_n(o_cs_n), .o_rd_n(o_rd_n), .o_chan_sel(o_chan_sel), .i_result_bus(bus),
    .i_wait(wait_lvl), .i_done_n(done_n));
  hfh_dev_model i_hfh_dev_model (.i_clk(i_clk), .i_mode(i_mode), .i_hang(hang),
    .i_cs_n(o_cs_n), .i_rd_n(o_rd_n), .i_chan_sel(o_chan_sel), .o_result_bus(bus),
    .o_wait(wait_lvl), .o_done_n(done_n));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic restart(input hfh_mode_t m, input logic bip);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    i_mode <= m;
    i_bipolar <= bip;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask
  // One read; returns once the port is idle again
  task automatic do_read(input logic [2:0] c);
    int n;
    got = 1'b0;
    @(posedge i_clk);
    i_req <= 1'b1;
    i_chan <= c;
    @(posedge i_clk);
    i_req <= 1'b0;
    for (n = 0; n < 3000 && !got && !to_seen; n++) begin
      @(negedge i_clk);
      got = o_valid === 1'b1;
      if (o_timeout === 1'b1) to_seen = 1'b1;
    end
    for (n = 0; n < 1000 && o_busy !== 1'b0; n++) @(negedge i_clk);
  endtask
  task automatic t_stall();
    restart(HFH_STALL, 1'b0);
    for (int c = 0; c < 8; c++) begin
      do_read(3'(c));
      check("stall valid", 8'(got), 8'h01);
      check("stall data", o_data, {3'(c), 5'h0b});
      check("chan pins", 8'(o_chan_sel), 8'(c));
      check("data chan", 8'(o_data_chan), 8'(c));
      check("done idle", 8'(done_n), 8'h01);
    end
  endtask
  task automatic t_bipolar();
    restart(HFH_STALL, 1'b1);
    do_read(3'h5);
    check("bipolar data", o_data, 8'hab ^ 8'h80);
  endtask
  task automatic t_pipe();
    restart(HFH_PIPE, 1'b0);
    do_read(3'h3);
    do_read(3'h6);
    check("pipe data", o_data, 8'h6b);
    check("pipe chan", 8'(o_data_chan), 8'h03);
    check("pipe done", 8'(done_n), 8'h00);
    do_read(3'h1);
    check("pipe next", o_data, 8'hcb);
  endtask
  task automatic t_hang();
    restart(HFH_STALL, 1'b0);
    hang <= 1'b1;
    to_seen = 1'b0;
    do_read(3'h2);
    check("timeout", 8'(to_seen), 8'h01);
  endtask
  // Requests while frozen must not start a read
  task automatic t_freeze();
    restart(HFH_STALL, 1'b0);
    @(posedge i_clk);
    ce <= 1'b0;
    i_req <= 1'b1;
    i_chan <= 3'h4;
    repeat (4) @(posedge i_clk);
    i_req <= 1'b0;
    @(negedge i_clk);
    check("frozen cs", 8'(o_cs_n), 8'h01);
    check("frozen rd", 8'(o_rd_n), 8'h01);
    check("frozen busy", 8'(o_busy), 8'h00);
    @(posedge i_clk);
    ce <= 1'b1;
    do_read(3'h4);
    check("thawed data", o_data, {3'h4, 5'h0b});
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    $display("ERROR watchdog expected done seen hang");
    finish_test();
  end
  initial begin
    t_stall();
    t_bipolar();
    t_pipe();
    t_freeze();
    t_hang();
    finish_test();
  end
endmodule // tb
